// ==== timer_load_match_update.sv ====
// Summary of operation
// - default reload applies at once: counting down it replaces the count, counting up the count restarts at zero
// - deferred reload enters counter at next zero
// - default match value becomes active at once
// - deferred match switches at next down zero
// - defer selections matter only when counting down
// - update modes per half A, B, both
// - live count readable, full 64 bits too
// - prescaler, split only: lsb for down periodic/oneshot, else msb
// - match sets capture interrupt and pwm duty
//
// Chosen here: the register addresses and the APB interface to the registers.
module timer_load_match_update
	import tmr_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               nrst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	output logic      [HALVES-1:0]  match_evt,
	output logic      [HALVES-1:0]  pwm_out
);
	typedef struct packed {
		logic                    split;
		half_cfg_t [HALVES-1:0]  cfg;
		logic [CNT_W-1:0]        snap_hi;
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
		logic [HALVES-1:0]       match_evt;
		logic [HALVES-1:0]       pwm_out;
	} top_st_t;

	top_st_t                 st_r;
	top_st_t                 st_nxt;
	half_cfg_t [HALVES-1:0]  eff_cfg;
	half_wr_t  [HALVES-1:0]  hwr;
	half_view_t [HALVES-1:0] hv;
	logic [HALVES-1:0]       ext_step;
	logic [HALVES-1:0]       zero_in;
	logic [HALVES-1:0]       wrap;
	logic [HALVES-1:0]       hit;
	logic                    acc;
	logic                    wr_go;
	logic                    rd_go;
	logic                    mapped;
	logic [31:0]             rd_word;

	// one wait state: the access phase answers on its second edge
	// first access edge: the read word is registered and pready rises
	// second access edge: the master samples pready and a write lands, with
	// the request still held, so a master that drops the request early loses it
	// a longer wait would only cost time, since every register is local
	assign acc   = psel & penable & ~st_r.pready;
	assign wr_go = psel & penable & st_r.pready & pwrite & mapped;
	assign rd_go = acc & ~pwrite;

	// register map, byte offsets, one aligned word each:
	//   0x00 configuration, bit 0 splits the pair into two halves
	//   0x04 / 0x08 half A / half B control: enable, direction, mode
	//   0x0C update mode: select bits for A and B, reload and match defer
	//   0x10 / 0x14 reload value of half A / half B
	//   0x18 / 0x1C match value of half A / half B
	//   0x20 / 0x24 prescale load of half A / half B
	//   0x28 / 0x2C live count of half A / half B
	//   0x30 both live prescalers, half B in the upper half word
	// anything else answers with an error and reads as zero
	// address decode
	always_comb begin
		unique case (paddr)
			OFS_CFG, OFS_CTRL_A, OFS_CTRL_B, OFS_UPD, OFS_LOAD_A, OFS_LOAD_B,
			OFS_MTCH_A, OFS_MTCH_B, OFS_PRE_A, OFS_PRE_B, OFS_VAL_A, OFS_VAL_B,
			OFS_PREVAL: mapped = 1'b1;
			default:    mapped = 1'b0;
		endcase
	end

	// read mux; programmed values read from the shadows
	// a read has no side effect apart from the upper-word snapshot
	always_comb begin
		rd_word = RST_WORD;
		unique case (paddr)
			OFS_CFG:    rd_word[CFG_SPLIT] = st_r.split;
			OFS_CTRL_A: begin
				rd_word[CTL_EN]                = st_r.cfg[0].enable;
				rd_word[CTL_UP]                = st_r.cfg[0].count_up;
				rd_word[CTL_MODE_H:CTL_MODE_L] = st_r.cfg[0].mode;
			end
			OFS_CTRL_B: begin
				rd_word[CTL_EN]                = st_r.cfg[1].enable;
				rd_word[CTL_UP]                = st_r.cfg[1].count_up;
				rd_word[CTL_MODE_H:CTL_MODE_L] = st_r.cfg[1].mode;
			end
			OFS_UPD: begin
				rd_word[UPD_SEL_A] = 1'b1;
				rd_word[UPD_SEL_B] = st_r.split;
				rd_word[UPD_RLD]   = st_r.cfg[0].reload_defer;
				rd_word[UPD_CMP]   = st_r.cfg[0].compare_defer;
			end
			OFS_LOAD_A: rd_word = hv[0].reload_shd;
			OFS_LOAD_B: rd_word = hv[1].reload_shd;
			OFS_MTCH_A: rd_word = hv[0].match_shd;
			OFS_MTCH_B: rd_word = hv[1].match_shd;
			OFS_PRE_A:  rd_word[PRE_W-1:0] = hv[0].pre_load;
			OFS_PRE_B:  rd_word[PRE_W-1:0] = hv[1].pre_load;
			OFS_VAL_A:  rd_word = hv[0].count;
			// full width: upper word comes from the snapshot taken with the lower read
			OFS_VAL_B:  rd_word = st_r.split ? hv[1].count : st_r.snap_hi;
			OFS_PREVAL: rd_word = {hv[1].pre, hv[0].pre};
			default:    rd_word = RST_WORD;
		endcase
	end

	// in full width half B follows half A's settings and is fed by A's carry
	// A's wrap is the carry, so B moves once per period of A
	generate
		for (genvar h = 0; h < HALVES; h++) begin : g_half
			if (h == 0) begin : g_lo
				assign ext_step[h] = 1'b1;
				assign eff_cfg[h]  = st_r.cfg[h];
			end else begin : g_hi
				assign ext_step[h] = st_r.split ? 1'b1 : wrap[0];
				assign eff_cfg[h]  = st_r.split ? st_r.cfg[h] : st_r.cfg[0];
			end
			// a full-width zero needs both words at zero
			assign zero_in[h] = st_r.split ? hv[h].at_zero : hv[0].at_zero & hv[1].at_zero;

			// write strobes; each half takes only its own register writes, so in
			// full width software writes the upper word to B and the lower to A
			always_comb begin
				hwr[h]          = '0;
				hwr[h].wdata    = pwdata;
				hwr[h].load_wr  = wr_go & (paddr == (h == 0 ? OFS_LOAD_A : OFS_LOAD_B));
				hwr[h].match_wr = wr_go & (paddr == (h == 0 ? OFS_MTCH_A : OFS_MTCH_B));
				hwr[h].pre_wr   = wr_go & (paddr == (h == 0 ? OFS_PRE_A : OFS_PRE_B));
			end

			timer_half u_half (
				.core_clk (core_clk),
				.nrst     (nrst),
				.cfg      (eff_cfg[h]),
				.use_pre  (st_r.split),
				.ext_step (ext_step[h]),
				.zero_in  (zero_in[h]),
				.wr       (hwr[h]),
				.view     (hv[h]),
				.wrap     (wrap[h]),
				.hit      (hit[h])
			);
		end
	endgenerate

	// bus answer, configuration writes and registered outputs
	always_comb begin
		st_nxt         = st_r;
		st_nxt.pready  = acc;
		st_nxt.pslverr = acc & ~mapped;
		if (rd_go) begin
			st_nxt.prdata = mapped ? rd_word : RST_WORD;
		end
		// the upper word is frozen when the lower word is read, so a carry
		// between the two reads cannot tear the 64-bit value
		if (rd_go && paddr == OFS_VAL_A && !st_r.split) begin
			st_nxt.snap_hi = hv[1].count;
		end
		if (wr_go) begin
			unique case (paddr)
				OFS_CFG: st_nxt.split = pwdata[CFG_SPLIT];
				OFS_CTRL_A, OFS_CTRL_B: begin
					for (int i = 0; i < HALVES; i++) begin
						if (paddr == (i == 0 ? OFS_CTRL_A : OFS_CTRL_B)) begin
							st_nxt.cfg[i].enable   = pwdata[CTL_EN];
							st_nxt.cfg[i].count_up = pwdata[CTL_UP];
							st_nxt.cfg[i].mode     = tmr_mode_t'(pwdata[CTL_MODE_H:CTL_MODE_L]);
						end
					end
				end
				OFS_UPD: begin
					// select bits pick A, B or both; B is ignored when not split
					// the defer bits only take hold while a half counts down
					if (pwdata[UPD_SEL_A]) begin
						st_nxt.cfg[0].reload_defer  = pwdata[UPD_RLD];
						st_nxt.cfg[0].compare_defer = pwdata[UPD_CMP];
					end
					if (pwdata[UPD_SEL_B] && st_r.split) begin
						st_nxt.cfg[1].reload_defer  = pwdata[UPD_RLD];
						st_nxt.cfg[1].compare_defer = pwdata[UPD_CMP];
					end
				end
				default: st_nxt.split = st_r.split;
			endcase
		end
		// match event marks the interrupt point in capture count, pwm level sets duty
		// both look at the active match only, so a deferred value cannot
		// disturb the duty cycle in mid-period
		for (int i = 0; i < HALVES; i++) begin
			st_nxt.match_evt[i] = hit[i] & eff_cfg[i].mode == MODE_CAPCNT;
			st_nxt.pwm_out[i]   = eff_cfg[i].enable & eff_cfg[i].mode == MODE_PWM
				& hv[i].count > hv[i].match_act;
		end
	end

	// state register
	// one register for all top state keeps reset and update in one place
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// every output is a register bit, so nothing combinational reaches a pin
	assign prdata    = st_r.prdata;
	assign pready    = st_r.pready;
	assign pslverr   = st_r.pslverr;
	assign match_evt = st_r.match_evt;
	assign pwm_out   = st_r.pwm_out;
endmodule : timer_load_match_update

// ==== tmr_pkg.sv ====
package tmr_pkg;
	localparam int          CNT_W      = 32;
	localparam int          PRE_W      = 16;
	localparam int          HALVES     = 2;
	localparam int          ADDR_W     = 8;
	// register byte offsets
	localparam logic [7:0]  OFS_CFG    = 8'h00;
	localparam logic [7:0]  OFS_CTRL_A = 8'h04;
	localparam logic [7:0]  OFS_CTRL_B = 8'h08;
	localparam logic [7:0]  OFS_UPD    = 8'h0C;
	localparam logic [7:0]  OFS_LOAD_A = 8'h10;
	localparam logic [7:0]  OFS_LOAD_B = 8'h14;
	localparam logic [7:0]  OFS_MTCH_A = 8'h18;
	localparam logic [7:0]  OFS_MTCH_B = 8'h1C;
	localparam logic [7:0]  OFS_PRE_A  = 8'h20;
	localparam logic [7:0]  OFS_PRE_B  = 8'h24;
	localparam logic [7:0]  OFS_VAL_A  = 8'h28;
	localparam logic [7:0]  OFS_VAL_B  = 8'h2C;
	localparam logic [7:0]  OFS_PREVAL = 8'h30;
	// field positions
	localparam int          CFG_SPLIT  = 0;
	localparam int          CTL_EN     = 0;
	localparam int          CTL_UP     = 1;
	localparam int          CTL_MODE_L = 2;
	localparam int          CTL_MODE_H = 3;
	localparam int          UPD_SEL_A  = 0;
	localparam int          UPD_SEL_B  = 1;
	localparam int          UPD_RLD    = 4;
	localparam int          UPD_CMP    = 5;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_ONESHOT  = 2'h0,
		MODE_PERIODIC = 2'h1,
		MODE_CAPCNT   = 2'h2,
		MODE_PWM      = 2'h3
	} tmr_mode_t;

	// per-half configuration; defer bits clear means reload_apply_now / compare_apply_now
	typedef struct packed {
		logic      enable;
		logic      count_up;
		tmr_mode_t mode;
		logic      reload_defer;
		logic      compare_defer;
	} half_cfg_t;

	// software write strobes towards one half
	typedef struct packed {
		logic             load_wr;
		logic             match_wr;
		logic             pre_wr;
		logic [CNT_W-1:0] wdata;
	} half_wr_t;

	// live view of one half
	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic [PRE_W-1:0] pre;
		logic [CNT_W-1:0] reload_shd;
		logic [CNT_W-1:0] match_shd;
		logic [CNT_W-1:0] match_act;
		logic [PRE_W-1:0] pre_load;
		logic             at_zero;
	} half_view_t;
endpackage : tmr_pkg

// ==== timer_half.sv ====
module timer_half
	import tmr_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire half_cfg_t  cfg,
	input  wire logic       use_pre,
	input  wire logic       ext_step,
	input  wire logic       zero_in,
	input  wire half_wr_t   wr,
	output half_view_t      view,
	output logic            wrap,
	output logic            hit
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [PRE_W-1:0] pre;
		logic [PRE_W-1:0] pre_load;
		logic [CNT_W-1:0] reload_act;
		logic [CNT_W-1:0] reload_shd;
		logic             reload_pend;
		logic [CNT_W-1:0] match_act;
		logic [CNT_W-1:0] match_shd;
		logic             match_pend;
		logic             done;
	} half_st_t;

	half_st_t st_r;
	half_st_t st_nxt;
	logic     down;
	logic     pre_lsb;
	logic     active;
	logic     cnt_step;
	logic     xfer;

	// prescaler role and the main counter's advance condition
	assign down     = ~cfg.count_up;
	assign pre_lsb  = use_pre & down & (cfg.mode == MODE_ONESHOT | cfg.mode == MODE_PERIODIC);
	assign active   = cfg.enable & ~st_r.done;
	assign cnt_step = active & ext_step & (~pre_lsb | st_r.pre == '0);
	assign wrap     = cnt_step & (down ? st_r.cnt == '0 : st_r.cnt == st_r.reload_act);
	// while counting down, deferred values move over only on a pass through zero
	assign xfer     = down & zero_in & cnt_step;
	assign hit      = active & st_r.cnt == st_r.match_act;

	assign view.count      = st_r.cnt;
	assign view.pre        = st_r.pre;
	assign view.reload_shd = st_r.reload_shd;
	assign view.match_shd  = st_r.match_shd;
	assign view.match_act  = st_r.match_act;
	assign view.pre_load   = st_r.pre_load;
	assign view.at_zero    = st_r.cnt == '0 & (pre_lsb | ~use_pre | st_r.pre == '0);

	// counting, prescaling and load/match hand-over
	always_comb begin
		st_nxt = st_r;
		if (cnt_step) begin
			if (down) begin
				st_nxt.cnt = wrap ? st_r.reload_act : st_r.cnt - 1'b1;
			end else begin
				st_nxt.cnt = wrap ? '0 : st_r.cnt + 1'b1;
			end
			if (wrap && cfg.mode == MODE_ONESHOT) begin
				st_nxt.cnt  = st_r.cnt;
				st_nxt.done = 1'b1;
			end
		end
		// lsb role: divider ahead of the counter; msb role: extension above it
		if (use_pre && active && ext_step) begin
			if (pre_lsb) begin
				st_nxt.pre = st_r.pre == '0 ? st_r.pre_load : st_r.pre - 1'b1;
			end else if (wrap) begin
				if (down) begin
					st_nxt.pre = st_r.pre == '0 ? st_r.pre_load : st_r.pre - 1'b1;
				end else begin
					st_nxt.pre = st_r.pre == st_r.pre_load ? '0 : st_r.pre + 1'b1;
				end
			end
		end
		if (xfer && st_r.reload_pend) begin
			st_nxt.reload_act  = st_r.reload_shd;
			st_nxt.cnt         = st_r.reload_shd;
			st_nxt.reload_pend = 1'b0;
		end
		if (xfer && st_r.match_pend) begin
			st_nxt.match_act  = st_r.match_shd;
			st_nxt.match_pend = 1'b0;
		end
		// pending values are released at once if the direction turns to up
		if (!down && st_r.reload_pend) begin
			st_nxt.reload_act  = st_r.reload_shd;
			st_nxt.reload_pend = 1'b0;
		end
		if (!down && st_r.match_pend) begin
			st_nxt.match_act  = st_r.match_shd;
			st_nxt.match_pend = 1'b0;
		end
		// software writes come last so a write beats a same-cycle transfer
		if (wr.load_wr) begin
			st_nxt.reload_shd = wr.wdata;
			st_nxt.done       = 1'b0;
			if (cfg.reload_defer && down) begin
				st_nxt.reload_pend = 1'b1;
			end else begin
				st_nxt.reload_act  = wr.wdata;
				st_nxt.cnt         = down ? wr.wdata : '0;
				st_nxt.reload_pend = 1'b0;
			end
		end
		if (wr.match_wr) begin
			st_nxt.match_shd = wr.wdata;
			if (cfg.compare_defer && down) begin
				st_nxt.match_pend = 1'b1;
			end else begin
				st_nxt.match_act  = wr.wdata;
				st_nxt.match_pend = 1'b0;
			end
		end
		if (wr.pre_wr) begin
			st_nxt.pre_load = wr.wdata[PRE_W-1:0];
			st_nxt.pre      = wr.wdata[PRE_W-1:0];
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : timer_half

// ==== tmr_checker_asserts.sv ====
module tmr_checker
	import tmr_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              nrst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [HALVES-1:0] match_evt,
	input wire logic [HALVES-1:0] pwm_out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// one access phase, then the single answer cycle
	sequence s_acc; psel && penable && !pready; endsequence
	sequence s_ans; pready ##1 !pready; endsequence
	AST_ANSWER: assert property (s_acc |=> s_ans) else $error("late answer");
	AST_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
	// unmapped means beyond the last register or not word aligned
	AST_ERR_ONLY: assert property (pslverr |-> pready
		&& (paddr > OFS_PREVAL || paddr[1:0] != 2'h0)) else $error("error on mapped");
	AST_ERR_MAP: assert property (pready
		&& (paddr > OFS_PREVAL || paddr[1:0] != 2'h0) |-> pslverr) else $error("no error unmapped");
	AST_ZERO_RD: assert property (pready && pslverr && !pwrite |-> prdata == '0)
		else $error("unmapped read not zero");
	AST_UPD_RD: assert property (pready && !pwrite && paddr == OFS_UPD |-> prdata[0])
		else $error("update flag read");
	// leaving capture count must silence half A's match event within two cycles
	AST_EXCL: assert property (pready && pwrite && paddr == OFS_CTRL_A
		&& pwdata[CTL_MODE_H:CTL_MODE_L] != MODE_CAPCNT |-> ##2 !match_evt[0])
		else $error("match event outside capture count");
	// disabling half A must silence its outputs within two cycles
	AST_OFF: assert property (pready && pwrite && paddr == OFS_CTRL_A && !pwdata[CTL_EN]
		|-> ##2 !pwm_out[0] && !match_evt[0]) else $error("output after disable");
endmodule : tmr_checker

bind timer_load_match_update tmr_checker tmr_checker_i (
	.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.match_evt(match_evt), .pwm_out(pwm_out));

// ==== testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tmr_pkg::*;
	logic              core_clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rnd, lo, hi;
	logic [HALVES-1:0] match_evt, pwm_out;
	logic [31:0]       q_lo[$], q_hi[$];
	logic              q_err[$], err_e;
	int                n_errors, total_checks, cyc;

	timer_load_match_update timer_load_match_update_i (.core_clk(core_clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .match_evt(match_evt),
		.pwm_out(pwm_out));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL output exp %h got %h", e, g);
		end
	endtask : chk

	// apb master; read expectations queue up for the monitor
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, l, h);
		q_err.push_back(a > OFS_PREVAL || a[1:0] != 2'h0);
		if (!w) begin
			q_lo.push_back(l);
			q_hi.push_back(h);
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk) penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, e, e);
	endtask : rd

	// or of one output bit over a window; levels may dip at count zero
	task automatic win(input logic pwm, input int idx, input int n, input logic e);
		logic acc;
		acc = 1'b0;
		repeat (n) begin
			@(posedge core_clk);
			acc |= pwm ? pwm_out[idx] : match_evt[idx];
		end
		chk({31'h0, e}, {31'h0, acc});
	endtask : win

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	// bus monitor: oldest notes against the answer, range allows a running count
	always @(posedge core_clk) begin
		if (nrst && psel && penable && pready === 1'b1) begin
			err_e = q_err.pop_front();
			total_checks++;
			if (pslverr !== err_e) begin
				n_errors++;
				$display("FAIL pslverr %h exp %b got %b", paddr, err_e, pslverr);
			end
		end
		if (nrst && psel && penable && pready === 1'b1 && !pwrite) begin
			lo = q_lo.pop_front();
			hi = q_hi.pop_front();
			total_checks++;
			if ((prdata >= lo && prdata <= hi) !== 1'b1) begin
				n_errors++;
				$display("FAIL read %h exp %h got %h", paddr, lo, prdata);
			end
		end
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			close_out();
		end
	end

	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{n_errors, total_checks, cyc} = '0;
		rnd = 32'h0000_003E;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		rd(OFS_UPD, 32'h0000_0001);
		rd(OFS_LOAD_A, 32'h0);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			rnd = xs(rnd);
			wr(OFS_LOAD_A, rnd);
			wr(OFS_LOAD_B, ~rnd);
			rd(OFS_VAL_A, rnd);
			rd(OFS_VAL_B, ~rnd);
		end
		$display("test immediate load done");
		wr(OFS_LOAD_B, 32'h0);
		wr(OFS_LOAD_A, 32'h3);
		wr(OFS_UPD, 32'h0000_0011);
		rd(OFS_UPD, 32'h0000_0011);
		wr(OFS_LOAD_A, 32'h0000_1000);
		rd(OFS_LOAD_A, 32'h0000_1000);
		rd(OFS_VAL_A, 32'h3);
		wr(OFS_CTRL_A, 32'h0000_0005);
		repeat (20) @(posedge core_clk);
		wr(OFS_CTRL_A, 32'h0);
		apb(1'b0, OFS_VAL_A, 32'h0, 32'h0000_0FC0, 32'h0000_1000);
		wr(OFS_UPD, 32'h0000_0001);
		$display("test deferred load done");
		wr(OFS_CFG, 32'h1);
		wr(OFS_LOAD_B, 32'hFFFF_0000);
		wr(OFS_CTRL_B, 32'h0000_000D);
		wr(OFS_MTCH_B, 32'h0);
		win(1'b1, 1, 2, 1'b1);
		wr(OFS_MTCH_B, 32'hFFFF_FFFF);
		win(1'b1, 1, 4, 1'b0);
		wr(OFS_UPD, 32'h0000_0022);
		rd(OFS_UPD, 32'h0000_0003);
		wr(OFS_MTCH_B, 32'h0);
		rd(OFS_MTCH_B, 32'h0);
		win(1'b1, 1, 4, 1'b0);
		wr(OFS_LOAD_B, 32'h4);
		repeat (12) @(posedge core_clk);
		win(1'b1, 1, 6, 1'b1);
		wr(OFS_CTRL_B, 32'h0000_000F);
		wr(OFS_MTCH_B, 32'hFFFF_FFFF);
		win(1'b1, 1, 8, 1'b0);
		// back to down counting: the deferred match waits for the next zero
		wr(OFS_CTRL_B, 32'h0000_0009);
		wr(OFS_MTCH_B, 32'h3);
		win(1'b0, 1, 2, 1'b0);
		win(1'b0, 1, 8, 1'b1);
		$display("test match update done");
		wr(OFS_LOAD_A, 32'h5);
		wr(OFS_MTCH_A, 32'h5);
		wr(OFS_CTRL_A, 32'h0000_0009);
		win(1'b0, 0, 2, 1'b1);
		wr(OFS_MTCH_A, 32'h6);
		win(1'b0, 0, 4, 1'b0);
		// pwm on half A: level follows a count above the active match
		wr(OFS_CTRL_A, 32'h0000_000D);
		win(1'b1, 0, 4, 1'b0);
		wr(OFS_MTCH_A, 32'h0);
		win(1'b1, 0, 4, 1'b1);
		wr(OFS_CTRL_A, 32'h0);
		$display("test capture match done");
		close_out();
	end
endmodule : testbench
